// [logic/dio_transfer_map.svh]
// register map, field positions, reset values and timing counts of the dio engine
//
// Contract
// R01 - four modes: direct, timer, strobe, handshake
// R02 - 0x10 reads inputs, 0x14 drives outputs
// R03 - timer 0 paces input, timer 1 output
// R04 - one input FIFO push per input pacer pulse
// R05 - paced input drained to host by DMA
// R06 - external strobe latches inputs into FIFO
// R07 - handshake input: store word, then acknowledge
// R08 - DMA starts when FIFO holds data, bus free
// R09 - output FIFO fetched by DMA while not full
// R10 - load output word, then request once stable
// R11 - after acknowledge, load next word and request
// R12 - acknowledge held until request drops
// R13 - partner acknowledge low before output request
// R14 - next output request only after acknowledge seen
// R15 - polarity 1 latches falling, 0 rising edge
// R16 - overrun flag on push into full FIFO
// R17 - underrun flag on word need, FIFO empty
// R18 - timer 1 falling moves one output word
// R19 - reset stops transfers, empties FIFOs, drops strobes
// R20 - strobes synchronised before edge detection
`ifndef DIO_TRANSFER_MAP_SVH
`define DIO_TRANSFER_MAP_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define DIO_OFS_IN_LINES   8'h10
`define DIO_OFS_OUT_LINES  8'h14
`define DIO_OFS_CTRL       8'h18
`define DIO_OFS_POLARITY   8'h1C

// ***************************************************************
// control and polarity register fields
// ***************************************************************
`define DIO_BIT_IN_ACK_EN    0
`define DIO_BIT_IN_REQ_EN    1
`define DIO_BIT_IN_TIMER_EN  2
`define DIO_BIT_IN_FIFO_EN   3
`define DIO_BIT_IN_ENABLE    6
`define DIO_BIT_OUT_ACK_EN   7
`define DIO_BIT_OUT_REQ_EN   8
`define DIO_BIT_OUT_TIMER_EN 9
`define DIO_BIT_OUT_FIFO_EN  10
`define DIO_BIT_OVERRUN      14
`define DIO_BIT_UNDERRUN     16
`define DIO_BIT_POLARITY     12
`define DIO_CTRL_RESET       11'h000

// ***************************************************************
// timing
// ***************************************************************
`define DIO_CLK_PERIOD_NS    50
`define DIO_OUT_SETUP_NS     50
`define DIO_OUT_SETUP_CYCLES ((`DIO_OUT_SETUP_NS + `DIO_CLK_PERIOD_NS - 1) / `DIO_CLK_PERIOD_NS)

`endif

// [logic/dio_pkg.sv]
// types shared by the dio engine
`default_nettype none
package dio_pkg;
   typedef enum logic [1:0] {
      OUT_IDLE,
      OUT_SETTLE,
      OUT_REQUEST
   } dio_out_state_e;
endpackage : dio_pkg
`default_nettype wire

// [logic/dio_sync.sv]
// two flip-flop synchroniser for a group of level inputs
`default_nettype none
module dio_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : dio_sync
`default_nettype wire

// [logic/dio_fifo.sv]
// flip-flop fifo with valid/ready on both sides
`default_nettype none
module dio_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
) (
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH) + 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [CW-1:0]    count_reg;
   logic             push;
   logic             pop;

   assign in_ready  = (count_reg != CW'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data  = mem[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // reset empties the fifo [R19]
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_reg + 1'b1);
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_reg + 1'b1);
         end
         if (push && !pop) begin
            count_reg <= CW'(count_reg + 1'b1);
         end else if (pop && !push) begin
            count_reg <= CW'(count_reg - 1'b1);
         end
      end
   end
endmodule : dio_fifo
`default_nettype wire

// [logic/dio_transfer_engine.sv]
// parallel digital input/output transfer engine with paced, strobed and handshake modes
`include "dio_transfer_map.svh"
`default_nettype none
module dio_transfer_engine
   import dio_pkg::*;
#(
   parameter int DW        = 32,
   parameter int IN_DEPTH  = 16,
   parameter int OUT_DEPTH = 16
) (
   input  wire logic          core_clk,
   input  wire logic          reset_n,
   input  wire logic [7:0]    host_addr,
   input  wire logic          host_wr,
   input  wire logic          host_rd,
   input  wire logic [31:0]   host_wdata,
   output logic      [31:0]   host_rdata,
   output logic               host_rvalid,
   input  wire logic          host_bus_busy,
   output logic               dma_in_valid,
   input  wire logic          dma_in_ready,
   output logic      [DW-1:0] dma_in_data,
   input  wire logic          dma_out_valid,
   output logic               dma_out_ready,
   input  wire logic [DW-1:0] dma_out_data,
   input  wire logic [DW-1:0] in_lines,
   input  wire logic          in_request,
   output logic               in_ack,
   output logic      [DW-1:0] out_lines,
   output logic               out_request,
   input  wire logic          out_ack,
   input  wire logic          timer0_out,
   input  wire logic          timer1_out
);
   localparam logic [3:0] SETUP_CNT = 4'(`DIO_OUT_SETUP_CYCLES);

   // ***************************************************************
   // pin synchronisation and edge detection
   // ***************************************************************
   logic [DW+3:0] sync_q;
   logic [DW-1:0] in_lines_s;
   logic          in_req_s;
   logic          out_ack_s;
   logic          t0_s;
   logic          t1_s;
   logic          in_req_prev;
   logic          t0_prev;
   logic          t1_prev;
   logic          req_rise;
   logic          req_fall;
   logic          t0_fall;
   logic          t1_fall;

   // lines travel with the strobes so the sampled word lines up with its edge
   dio_sync #(.WIDTH(DW + 4)) u_pin_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .async_in ({in_lines, in_request, out_ack, timer0_out, timer1_out}),
      .sync_out (sync_q)
   ); // [R20]

   assign in_lines_s = sync_q[DW+3:4];
   assign in_req_s   = sync_q[3];
   assign out_ack_s  = sync_q[2];
   assign t0_s       = sync_q[1];
   assign t1_s       = sync_q[0];

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         in_req_prev <= 1'b0;
         t0_prev     <= 1'b0;
         t1_prev     <= 1'b0;
      end else begin
         in_req_prev <= in_req_s;
         t0_prev     <= t0_s;
         t1_prev     <= t1_s;
      end
   end

   assign req_rise = in_req_s && !in_req_prev;  // [R20]
   assign req_fall = !in_req_s && in_req_prev;
   assign t0_fall  = !t0_s && t0_prev;          // [R03]
   assign t1_fall  = !t1_s && t1_prev;          // [R03]

   // ***************************************************************
   // control and status registers
   // ***************************************************************
   logic [10:0] ctrl_reg;
   logic        input_strobe_polarity;
   logic        input_overrun_flag;
   logic        output_underrun_flag;
   logic        wr_ctrl;
   logic        overrun_set;
   logic        underrun_set;
   logic        in_ack_en;
   logic        in_req_en;
   logic        input_timer_pacing_enable;
   logic        in_fifo_en;
   logic        in_enable;
   logic        out_ack_en;
   logic        out_req_en;
   logic        output_timer_pacing_enable;
   logic        out_fifo_en;

   assign wr_ctrl                    = host_wr && (host_addr == `DIO_OFS_CTRL);
   assign in_ack_en                  = ctrl_reg[`DIO_BIT_IN_ACK_EN];
   assign in_req_en                  = ctrl_reg[`DIO_BIT_IN_REQ_EN];
   assign input_timer_pacing_enable  = ctrl_reg[`DIO_BIT_IN_TIMER_EN];
   assign in_fifo_en                 = ctrl_reg[`DIO_BIT_IN_FIFO_EN];
   assign in_enable                  = ctrl_reg[`DIO_BIT_IN_ENABLE];
   assign out_ack_en                 = ctrl_reg[`DIO_BIT_OUT_ACK_EN];
   assign out_req_en                 = ctrl_reg[`DIO_BIT_OUT_REQ_EN];
   assign output_timer_pacing_enable = ctrl_reg[`DIO_BIT_OUT_TIMER_EN];
   assign out_fifo_en                = ctrl_reg[`DIO_BIT_OUT_FIFO_EN];

   // timer, strobe and handshake modes come out of reset disabled [R19]
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= `DIO_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= host_wdata[10:0];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         input_strobe_polarity <= 1'b0;
      end else if (host_wr && (host_addr == `DIO_OFS_POLARITY)) begin
         input_strobe_polarity <= host_wdata[`DIO_BIT_POLARITY];
      end
   end

   // a new event in the clearing cycle wins over the write-one clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         input_overrun_flag <= 1'b0;
      end else if (overrun_set) begin
         input_overrun_flag <= 1'b1;                                   // [R16]
      end else if (wr_ctrl && host_wdata[`DIO_BIT_OVERRUN]) begin
         input_overrun_flag <= 1'b0;                                   // [R16]
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         output_underrun_flag <= 1'b0;
      end else if (underrun_set) begin
         output_underrun_flag <= 1'b1;                                 // [R17]
      end else if (wr_ctrl && host_wdata[`DIO_BIT_UNDERRUN]) begin
         output_underrun_flag <= 1'b0;                                 // [R17]
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         host_rdata  <= 32'h00000000;
         host_rvalid <= 1'b0;
      end else begin
         host_rvalid <= host_rd;
         if (host_rd) begin
            case (host_addr)
               `DIO_OFS_IN_LINES:  host_rdata <= 32'(in_lines_s);       // [R02]
               `DIO_OFS_OUT_LINES: host_rdata <= 32'(out_lines);
               `DIO_OFS_CTRL: begin
                  host_rdata <= 32'(ctrl_reg);
                  host_rdata[`DIO_BIT_OVERRUN]  <= input_overrun_flag;
                  host_rdata[`DIO_BIT_UNDERRUN] <= output_underrun_flag;
               end
               `DIO_OFS_POLARITY: begin
                  host_rdata <= 32'h00000000;
                  host_rdata[`DIO_BIT_POLARITY] <= input_strobe_polarity;
               end
               default: host_rdata <= 32'h00000000;
            endcase
         end
      end
   end

   // ***************************************************************
   // input sampling
   // ***************************************************************
   logic          timer_mode;
   logic          strobe_mode;
   logic          hs_mode;
   logic          strobe_edge;
   logic          sample_evt;
   logic          push_req;
   logic          in_fifo_ready;
   logic          in_fifo_valid;
   logic [DW-1:0] in_fifo_data;
   logic          buf_ready;
   logic          buf_valid;
   logic          pushed_hs_reg;

   assign timer_mode  = in_enable && input_timer_pacing_enable;          // [R03]
   assign strobe_mode = in_enable && in_req_en && !in_ack_en;
   assign hs_mode     = in_enable && in_req_en && in_ack_en;
   assign strobe_edge = input_strobe_polarity ? req_fall : req_rise;     // [R15]

   // timer, strobe and handshake modes are alternative sample sources [R01]
   assign sample_evt = (timer_mode && t0_fall)                           // [R04]
                    || (strobe_mode && strobe_edge)                      // [R06]
                    || (hs_mode && req_rise && !in_ack);                 // [R07]
   assign push_req    = sample_evt && in_fifo_en;
   assign overrun_set = push_req && !in_fifo_ready;                      // [R16]

   // acknowledge follows the store and holds until the request drops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pushed_hs_reg <= 1'b0;
         in_ack        <= 1'b0;
      end else begin
         pushed_hs_reg <= hs_mode && req_rise && !in_ack;
         if (!hs_mode || !in_req_s) begin
            in_ack <= 1'b0;                                              // [R12]
         end else if (pushed_hs_reg) begin
            in_ack <= 1'b1;                                              // [R07]
         end
      end
   end

   dio_fifo #(.WIDTH(DW), .DEPTH(IN_DEPTH)) u_in_fifo (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .in_valid  (push_req),
      .in_ready  (in_fifo_ready),
      .in_data   (in_lines_s),
      .out_valid (in_fifo_valid),
      .out_ready (buf_ready),
      .out_data  (in_fifo_data)
   );

   // two-entry skid stage so a stalled host read never drops a word
   dio_fifo #(.WIDTH(DW), .DEPTH(2)) u_in_buf (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .in_valid  (in_fifo_valid),
      .in_ready  (buf_ready),
      .in_data   (in_fifo_data),
      .out_valid (buf_valid),
      .out_ready (dma_in_ready && !host_bus_busy),
      .out_data  (dma_in_data)
   );

   assign dma_in_valid = buf_valid && !host_bus_busy;                   // [R05] [R08]

   // ***************************************************************
   // output sequencing
   // ***************************************************************
   dio_out_state_e out_state_reg;
   logic [3:0]     settle_cnt_reg;
   logic           out_fifo_valid;
   logic [DW-1:0]  out_fifo_data;
   logic           need_word_reg;
   logic           load_req;
   logic           pop;
   logic           wr_out;

   dio_fifo #(.WIDTH(DW), .DEPTH(OUT_DEPTH)) u_out_fifo (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .in_valid  (dma_out_valid),
      .in_ready  (dma_out_ready),                                        // [R09]
      .in_data   (dma_out_data),
      .out_valid (out_fifo_valid),
      .out_ready (pop),
      .out_data  (out_fifo_data)
   );

   // a word is wanted on each timer 1 fall, or freely in request mode
   always_comb begin
      load_req = 1'b0;
      if (out_fifo_en && (out_state_reg == OUT_IDLE)) begin
         if (output_timer_pacing_enable) begin
            load_req = t1_fall;                                          // [R18]
         end else if (out_req_en && !(out_ack_en && out_ack_s)) begin
            // a stale synchronised acknowledge must not end the next request
            load_req = 1'b1;                                             // [R11] [R14]
         end
      end
   end

   assign pop          = load_req && out_fifo_valid;
   assign underrun_set = load_req && !out_fifo_valid
                       && (output_timer_pacing_enable || need_word_reg); // [R17]
   assign wr_out       = host_wr && (host_addr == `DIO_OFS_OUT_LINES);

   // a host write takes precedence over a word leaving the fifo
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_lines <= '0;
      end else if (wr_out) begin
         out_lines <= host_wdata[DW-1:0];                                // [R02]
      end else if (pop) begin
         out_lines <= out_fifo_data;                                     // [R10] [R18]
      end
   end

   // underrun is flagged once per missed word, not every idle cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         need_word_reg <= 1'b0;
      end else if (pop || !out_fifo_en) begin
         need_word_reg <= 1'b0;
      end else if (underrun_set) begin
         need_word_reg <= 1'b0;
      end else if ((out_state_reg == OUT_REQUEST) && (!out_ack_en || out_ack_s)) begin
         need_word_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_state_reg  <= OUT_IDLE;
         settle_cnt_reg <= 4'h0;
      end else if (!out_fifo_en) begin
         out_state_reg  <= OUT_IDLE;
         settle_cnt_reg <= 4'h0;
      end else begin
         case (out_state_reg)
            OUT_IDLE: begin
               if (pop && out_req_en) begin
                  out_state_reg  <= OUT_SETTLE;                          // [R10]
                  settle_cnt_reg <= SETUP_CNT;
               end
            end
            OUT_SETTLE: begin
               if (settle_cnt_reg <= 4'h1) begin
                  out_state_reg <= OUT_REQUEST;                          // [R10]
               end else begin
                  settle_cnt_reg <= settle_cnt_reg - 4'h1;
               end
            end
            OUT_REQUEST: begin
               // the partner drops its acknowledge before this request [R13]
               if (!out_ack_en || out_ack_s) begin
                  out_state_reg <= OUT_IDLE;                             // [R14]
               end
            end
            default: out_state_reg <= OUT_IDLE;
         endcase
      end
   end

   assign out_request = (out_state_reg == OUT_REQUEST);                  // [R19]

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   sequence hs_store_s;
      hs_mode && req_rise && !in_ack && in_fifo_en;
   endsequence

   sequence ack_answer_s;
      !in_ack ##2 in_ack;
   endsequence

   property ack_follows_store_p;
      hs_store_s |-> ack_answer_s or (##1 !(hs_mode && in_req_s));
   endproperty

   ack_after_store_a: assert property (ack_follows_store_p)  // [R07]
      else $error("input acknowledge did not follow the stored word");

   ack_hold_a: assert property (in_ack && in_req_s && hs_mode |=> in_ack)  // [R12]
      else $error("input acknowledge dropped while request still high");

   ack_cause_a: assert property ($rose(in_ack) |-> $past(pushed_hs_reg))  // [R07]
      else $error("input acknowledge raised without a stored word");

   overrun_set_a: assert property (push_req && !in_fifo_ready |=> input_overrun_flag)  // [R16]
      else $error("overrun flag not set on push into full fifo");

   underrun_set_a: assert property (underrun_set |=> output_underrun_flag)  // [R17]
      else $error("underrun flag not set on empty fifo load");

   timer_sample_a: assert property (
      timer_mode && in_fifo_en && t0_fall && in_fifo_ready |-> push_req)  // [R04]
      else $error("input pacer pulse did not push a word");

   strobe_edge_a: assert property (
      strobe_mode && in_fifo_en && (input_strobe_polarity ? req_fall : req_rise)
      |-> push_req)  // [R15]
      else $error("selected strobe edge did not latch the inputs");

   dma_gate_a: assert property (dma_in_valid |-> !host_bus_busy && buf_valid)  // [R08]
      else $error("input dma offered while host bus busy");

   req_stable_a: assert property (out_request && !wr_out |=> $stable(out_lines))  // [R10]
      else $error("output lines changed during output request");

   req_after_ack_a: assert property (
      out_request && out_ack_en && !out_ack_s && out_fifo_en |=> out_request)  // [R14]
      else $error("output request dropped before acknowledge seen");

   settle_req_a: assert property (
      (out_state_reg == OUT_IDLE) && pop && out_req_en && !wr_out
      |=> !out_request ##1 out_request)  // [R10]
      else $error("output request not raised one settle time after load");

   direct_write_a: assert property (wr_out |=> out_lines == $past(host_wdata[DW-1:0]))  // [R02]
      else $error("direct write did not reach the output lines");

endmodule : dio_transfer_engine
`default_nettype wire

// [testbench/dio_far_device.sv]
// far-side parallel device: input handshake source and output acknowledger
`default_nettype none
module dio_far_device (
   input  wire logic        core_clk,
   input  wire logic        out_request,
   input  wire logic        in_ack,
   output logic             in_request,
   output logic             out_ack,
   output logic [31:0]      in_lines
);
   timeunit 1ns;
   timeprecision 1ns;
   int ack_delay = 1;
   initial begin
      in_request = 1'b0;
      out_ack = 1'b0;
      in_lines = 32'h0;
   end
   task automatic put(input logic [31:0] w);
      in_lines = w;
   endtask : put
   // request held until acknowledge seen, then dropped
   task automatic hs_send(input logic [31:0] w);
      @(posedge core_clk) #2 in_lines = w;
      @(posedge core_clk) #2 in_request = 1'b1;
      for (int i = 0; i < 60 && in_ack !== 1'b1; i++) @(posedge core_clk);
      #2 in_request = 1'b0;
      // released lines flip so a stale word cannot pass
      in_lines = ~w;
      for (int i = 0; i < 60 && in_ack !== 1'b0; i++) @(posedge core_clk);
   endtask : hs_send
   // lone strobe; the word changes while high, so only the falling edge sees w
   task automatic strobe(input logic [31:0] w);
      @(posedge core_clk) #2 in_lines = ~w;
      in_request = 1'b1;
      repeat (3) @(posedge core_clk);
      #2 in_lines = w;
      repeat (3) @(posedge core_clk);
      #2 in_request = 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : strobe
   // acknowledge stays low until a request, then rises after a delay
   always @(posedge core_clk) begin
      if (out_request === 1'b1 && !out_ack) begin
         repeat (ack_delay) @(posedge core_clk);
         #2 out_ack = 1'b1;
      end else if (out_request === 1'b0 && out_ack) begin
         #2 out_ack = 1'b0;
      end
   end
endmodule : dio_far_device
`default_nettype wire

// [testbench/tb_dio_transfer_engine.sv]
// self-checking bench for the dio transfer engine
`include "dio_transfer_map.svh"
`default_nettype none
module tb_dio_transfer_engine;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 1'b0, reset_n = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
   logic [7:0]  host_addr = 8'h00;
   logic [31:0] host_wdata = 32'h0, dma_out_data = 32'h0, host_rdata, dma_in_data, w;
   logic        host_bus_busy = 1'b0, dma_in_ready = 1'b0, dma_out_valid = 1'b0;
   logic        timer0_out = 1'b1, timer1_out = 1'b1, req_q = 1'b0, saw_full = 1'b0;
   logic        host_rvalid, dma_in_valid, dma_out_ready, in_request, in_ack;
   logic        out_request, out_ack;
   logic [31:0] in_lines, out_lines;
   logic [31:0] rd_q[$], in_q[$], out_q[$];
   int          n_errors = 0, tests_run = 0, cyc = 0;
   // small fifos so that a slow far side fills them quickly
   dio_transfer_engine #(.IN_DEPTH(2), .OUT_DEPTH(2)) dio_transfer_engine_inst (.*);
   dio_far_device dio_far_device_inst (.*);
   always #25 core_clk = ~core_clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk) #2 host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(posedge core_clk) #2 host_wr = 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk) #2 host_addr = a;
      host_rd = 1'b1;
      rd_q.push_back(e);
      @(posedge core_clk) #2 host_rd = 1'b0;
      repeat (2) @(posedge core_clk);
   endtask : reg_rd
   // ***********************************
   // monitors: oldest note against result
   // ***********************************
   always @(posedge core_clk) begin
      if (++cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
      if (host_rvalid === 1'b1) check(host_rdata, rd_q.pop_front());
      if (dma_in_valid === 1'b1 && dma_in_ready) check(dma_in_data, in_q.pop_front());
      if (host_bus_busy) check(32'(dma_in_valid), 32'h0);
      if (out_request === 1'b1 && !req_q) check(out_lines, out_q.pop_front());
      req_q <= out_request;
      if (dma_out_valid && dma_out_ready === 1'b0) saw_full <= 1'b1;
      #2 dma_in_ready = $urandom_range(3) != 0;
      host_bus_busy = $urandom_range(7) == 0;
   end
   initial begin
      void'($urandom(72643));
      repeat (4) @(posedge core_clk);
      #2 reset_n = 1'b1;
      w = $urandom();
      dio_far_device_inst.put(w);
      repeat (4) @(posedge core_clk);
      reg_rd(`DIO_OFS_IN_LINES, w);
      reg_wr(`DIO_OFS_OUT_LINES, ~w);
      check(out_lines, ~w);
      reg_rd(`DIO_OFS_OUT_LINES, ~w);
      reg_rd(8'h20, 32'h0);
      $display("test direct done");
      reg_wr(`DIO_OFS_CTRL, 32'h4B);
      for (int i = 0; i < 6; i++) begin
         w = $urandom();
         in_q.push_back(w);
         dio_far_device_inst.hs_send(w);
      end
      $display("test handshake input done");
      reg_wr(`DIO_OFS_POLARITY, 32'h1000);
      reg_rd(`DIO_OFS_POLARITY, 32'h1000);
      reg_wr(`DIO_OFS_CTRL, 32'h4A);
      for (int i = 0; i < 4; i++) begin
         w = $urandom();
         in_q.push_back(w);
         dio_far_device_inst.strobe(w);
      end
      $display("test strobe input done");
      reg_wr(`DIO_OFS_CTRL, 32'h4C);
      for (int i = 0; i < 6; i++) begin
         w = $urandom();
         dio_far_device_inst.put(w);
         in_q.push_back(w);
         repeat (4) @(posedge core_clk);
         #2 timer0_out = 1'b0;
         repeat (4) @(posedge core_clk);
         #2 timer0_out = 1'b1;
      end
      repeat (30) @(posedge core_clk);
      check(32'(in_q.size()), 32'h0);
      $display("test paced input done");
      // slow acknowledge so the output fifo fills and refuses
      dio_far_device_inst.ack_delay = 6;
      reg_wr(`DIO_OFS_CTRL, 32'h580);
      for (int i = 0; i < 8; i++) begin
         w = $urandom();
         dma_out_data = w;
         dma_out_valid = 1'b1;
         for (int k = 0; k < 200; k++) begin
            @(posedge core_clk);
            if (dma_out_ready === 1'b1) break;
         end
         out_q.push_back(w);
         #2;
      end
      dma_out_valid = 1'b0;
      repeat (200) @(posedge core_clk);
      check(32'(out_q.size()), 32'h0);
      check(32'(saw_full), 32'h1);
      reg_rd(`DIO_OFS_CTRL, 32'h10580);
      reg_wr(`DIO_OFS_CTRL, 32'h0);
      reg_wr(`DIO_OFS_CTRL, 32'h10000);
      reg_rd(`DIO_OFS_CTRL, 32'h0);
      $display("test handshake output done");
      report_and_stop();
   end
endmodule : tb_dio_transfer_engine
`default_nettype wire
